//--- bench/dscp_host.sv
`timescale 1ns/1ps
module dscp_host (
	output logic sclk,
	output logic cs_n,
	output logic pin,
	output wire logic sdio,
	input wire logic sdo,
	input wire logic oe
);
	logic drv;
	logic en;
	// one shared pin, inverse of last when free
	assign sdio = oe ? sdo : (en ? drv : ~drv);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b0;
		pin = 1'b0;
		drv = 1'b0;
		en = 1'b0;
		// deselect edge while power reset still holds the link cleared
		#10 cs_n = 1'b1;
	end
	task automatic pulse(input int ns);
		pin = 1'b1;
		#(ns);
		pin = 1'b0;
	endtask
	task automatic frame(input logic [7:0] ins, input logic [31:0] wd, input logic lsb, input int bits,
		output logic [31:0] rd);
		int j;
		rd = 32'h0;
		cs_n = 1'b0;
		for (int i = 0; i < bits; i++) begin
			j = lsb ? i % 8 : 7 - i % 8;
			en = !(ins[7] && i >= 8);
			drv = i < 8 ? ins[j] : wd[8 * (i / 8 - 1) + j];
			#7.5 sclk = 1'b1;
			if (i >= 8) rd[8 * (i / 8 - 1) + j] = sdio;
			#7.5 sclk = 1'b0;
			if (i % 8 == 7 && i > 8) #400;
		end
		#7.5 cs_n = 1'b1;
		en = 1'b0;
		// deselect gap before the next frame
		#30;
	endtask
endmodule

//--- bench/dscp_top_props.sv
`timescale 1ns/1ps
module dscp_top_props (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic SDIO_I,
	input wire logic SDIO_O,
	input wire logic SDIO_OE,
	input wire logic RESET_MODE_PIN,
	input wire logic STRAP_PIN_MODE,
	input wire logic LOW_BIT_FIRST_SELECT,
	input wire logic [255:0] CFG_REGS
);
	// rising serial edges seen in this frame
	logic [3:0] rise_ff;
	always_ff @(posedge SCLK or posedge CS_N or posedge RESET_MODE_PIN) begin
		if (CS_N || RESET_MODE_PIN) begin
			rise_ff <= 4'h0;
		end else if (rise_ff != 4'hf) begin
			rise_ff <= rise_ff + 4'h1;
		end
	end
	sequence s_pin_fall;
		$fell(RESET_MODE_PIN);
	endsequence
	sequence s_pin_held;
		RESET_MODE_PIN [*8];
	endsequence
	a_oe_cs_idle: assert property (@(posedge MCLK) disable iff (!NRST) CS_N |-> !SDIO_OE)
		else $error("pin driven while deselected");
	a_nrst_clear: assert property (@(posedge MCLK) disable iff (!NRST) $rose(NRST) |-> CFG_REGS == 256'h0)
		else $error("registers not cleared");
	a_pin_defaults: assert property (@(posedge MCLK) disable iff (!NRST) s_pin_fall |-> ##[1:8] CFG_REGS == 256'h0)
		else $error("defaults not loaded");
	a_pin_blocks: assert property (@(posedge MCLK) disable iff (!NRST) s_pin_held |=> $stable(CFG_REGS))
		else $error("write while pin high");
	a_strap_rise: assert property (@(posedge MCLK) disable iff (!NRST) $rose(RESET_MODE_PIN) |-> ##[1:4] STRAP_PIN_MODE)
		else $error("strap mode missed");
	a_strap_fall: assert property (@(posedge MCLK) disable iff (!NRST) s_pin_fall |-> ##[1:4] !STRAP_PIN_MODE)
		else $error("strap mode stuck");
	a_order_mirror: assert property (@(posedge MCLK) disable iff (!NRST)
		CFG_REGS[6] != LOW_BIT_FIRST_SELECT |-> ##[1:4] CFG_REGS[6] == LOW_BIT_FIRST_SELECT)
		else $error("order bit differs");
	a_instr_no_oe: assert property (@(posedge SCLK) disable iff (CS_N || RESET_MODE_PIN) rise_ff < 4'h8 |-> !SDIO_OE)
		else $error("pin driven in instruction");
endmodule

bind dscp_top dscp_top_props u_props (.MCLK(MCLK), .NRST(NRST), .SCLK(SCLK), .CS_N(CS_N), .SDIO_I(SDIO_I),
	.SDIO_O(SDIO_O), .SDIO_OE(SDIO_OE), .RESET_MODE_PIN(RESET_MODE_PIN), .STRAP_PIN_MODE(STRAP_PIN_MODE),
	.LOW_BIT_FIRST_SELECT(LOW_BIT_FIRST_SELECT), .CFG_REGS(CFG_REGS));

//--- bench/test_dscp_top.sv
`timescale 1ns/1ps
module test_dscp_top;
	logic mclk;
	logic nrst;
	wire logic sclk;
	wire logic cs_n;
	wire logic pin;
	wire logic sdio;
	logic sdo;
	logic oe;
	logic strap;
	logic lbf;
	logic [255:0] cfg;
	logic [31:0] rd;
	int fail_count = 0;
	int samples_checked = 0;
	dscp_top dut (.MCLK(mclk), .NRST(nrst), .SCLK(sclk), .CS_N(cs_n), .SDIO_I(sdio), .SDIO_O(sdo), .SDIO_OE(oe),
		.RESET_MODE_PIN(pin), .STRAP_PIN_MODE(strap), .LOW_BIT_FIRST_SELECT(lbf), .CFG_REGS(cfg));
	dscp_host host (.sclk(sclk), .cs_n(cs_n), .pin(pin), .sdio(sdio), .sdo(sdo), .oe(oe));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic settle();
		repeat (12) @(posedge mclk);
		#1;
	endtask
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		#200000;
		fail_count++;
		close_out();
	end
	initial begin
		nrst = 1'b1;
		#5 nrst = 1'b0;
		repeat (5) @(posedge mclk);
		#1 nrst = 1'b1;
		settle();
		check(cfg[31:0], 32'h0);
		check(strap, 1'b0);
		fork
			host.pulse(600);
			#400 check(strap, 1'b1);
		join
		settle();
		check(strap, 1'b0);
		fork
			host.frame(8'h65, 32'h44332211, 1'b0, 40, rd);
			#560 check(cfg[47:40], 8'h11);
		join
		settle();
		check(cfg[47:16], 32'h11223344);
		host.frame(8'he5, 32'h0, 1'b0, 40, rd);
		check(rd, 32'h44332211);
		host.frame(8'h41, 32'h00c3b2a1, 1'b0, 32, rd);
		settle();
		check({lbf, cfg[15:0]}, {1'b1, 16'ha1c3});
		host.frame(8'h3e, 32'h6b5a, 1'b1, 24, rd);
		host.frame(8'hdf, 32'h0, 1'b1, 32, rd);
		check(rd, 32'h006b6b6b);
		host.frame(8'h03, 32'h0f, 1'b1, 12, rd);
		settle();
		check(cfg[31:24], 8'h33);
		host.frame(8'h03, 32'h7e, 1'b1, 16, rd);
		settle();
		check(cfg[31:24], 8'h7e);
		fork
			host.frame(8'h04, 32'h99, 1'b1, 16, rd);
			#100 host.pulse(100);
		join
		settle();
		check({lbf, cfg == 256'h0}, 2'b01);
		host.frame(8'h02, 32'h5c, 1'b0, 16, rd);
		host.frame(8'h82, 32'h0, 1'b0, 16, rd);
		check(rd, 32'h5c);
		close_out();
	end
endmodule

//--- hdl/dscp_cfg.svh
`ifndef DSCP_CFG_SVH
`define DSCP_CFG_SVH

// instruction byte fields
`define DSCP_INS_RW_BIT 7
`define DSCP_INS_CNT_HI 6
`define DSCP_INS_CNT_LO 5
`define DSCP_INS_ADDR_HI 4
`define DSCP_INS_ADDR_LO 0
`define DSCP_INS_BITS 8
`define DSCP_DATA_BITS 8
`define DSCP_ADDR_BITS 5
`define DSCP_REG_COUNT 32
// address range ends
`define DSCP_ADDR_LOW_END 5'h00
`define DSCP_ADDR_HIGH_END 5'h1f
// serial configuration register and its order bit
`define DSCP_CTRL_ADDR 5'h00
`define DSCP_CTRL_LSB_FIRST_BIT 6
`define DSCP_CTRL_RESET 8'h00
`define DSCP_REG_RESET 8'h00
// reset/mode pulse least width
`define DSCP_RESET_PULSE_NS 50
`define DSCP_MCLK_NS 50
`define DSCP_RESET_PULSE_CYC ((`DSCP_RESET_PULSE_NS + `DSCP_MCLK_NS - 1) / `DSCP_MCLK_NS)
// link clock ceiling
`define DSCP_SCLK_MAX_MHZ 25

`endif

//--- hdl/dscp_link.sv
`timescale 1ns/1ps
`include "dscp_cfg.svh"
module dscp_link
	import dscp_pkg::*;
(
	input wire logic sclk,
	input wire logic port_rst_n,
	input wire logic hold_rst_n,
	input wire logic sdio_in,
	input wire logic lsb_first,
	input wire dscp_byte_t rd_byte,
	output dscp_byte_t rx_byte,
	output dscp_addr_t cur_addr,
	output dscp_addr_t wr_addr,
	output logic wr_tgl,
	output logic rd_active,
	output logic sdo_bit
);
	dscp_phase_t phase_ff;
	logic [2:0] bit_ff;
	logic [1:0] left_ff;
	logic rd_ff;
	dscp_addr_t addr_ff;
	dscp_addr_t wr_addr_ff;
	dscp_byte_t sh_ff;
	dscp_byte_t rx_ff;
	logic tgl_ff;
	logic drive_ff;
	dscp_byte_t tx_ff;
	logic out_ff;

	function automatic dscp_byte_t shift_in(input dscp_byte_t s, input logic b, input logic lsb);
		shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
	endfunction

	function automatic dscp_addr_t step_addr(input dscp_addr_t a, input logic lsb);
		step_addr = lsb ? ((a == `DSCP_ADDR_HIGH_END) ? a : a + 5'h01)
			: ((a == `DSCP_ADDR_LOW_END) ? a : a - 5'h01);
	endfunction

	wire dscp_byte_t nxt_sh = shift_in(sh_ff, sdio_in, lsb_first);
	wire byte_end = (bit_ff == 3'h7);

	// R1 R2 R3 R7 R8 R14 R17 instruction, data and done phases, byte-wise update
	always_ff @(posedge sclk or negedge port_rst_n) begin
		if (!port_rst_n) begin
			phase_ff <= DSCP_INSTR;
			bit_ff <= 3'h0;
			left_ff <= 2'h0;
			rd_ff <= 1'b0;
			addr_ff <= 5'h00;
			sh_ff <= 8'h00;
		end else begin
			sh_ff <= nxt_sh;
			bit_ff <= bit_ff + 3'h1;
			case (phase_ff)
				DSCP_INSTR: begin
					if (byte_end) begin
						rd_ff <= nxt_sh[`DSCP_INS_RW_BIT];
						left_ff <= nxt_sh[`DSCP_INS_CNT_HI:`DSCP_INS_CNT_LO];
						addr_ff <= nxt_sh[`DSCP_INS_ADDR_HI:`DSCP_INS_ADDR_LO];
						phase_ff <= DSCP_DATA;
					end
				end
				DSCP_DATA: begin
					if (byte_end) begin
						addr_ff <= step_addr(addr_ff, lsb_first);
						left_ff <= left_ff - 2'h1;
						if (left_ff == 2'h0) begin
							phase_ff <= DSCP_DONE;
						end
					end
				end
				default: begin
					bit_ff <= 3'h0;
				end
			endcase
		end
	end

	// R6 R8 write hand-off kept across deselect
	wire wr_done = (phase_ff == DSCP_DATA) && byte_end && !rd_ff;
	always_ff @(posedge sclk or negedge hold_rst_n) begin
		if (!hold_rst_n) begin
			rx_ff <= 8'h00;
			wr_addr_ff <= 5'h00;
			tgl_ff <= 1'b0;
		end else if (wr_done) begin
			rx_ff <= nxt_sh;
			wr_addr_ff <= addr_ff;
			tgl_ff <= ~tgl_ff;
		end
	end

	// R9 R15 R18 read data out on falling edge
	wire rd_phase = (phase_ff == DSCP_DATA) && rd_ff;
	wire [2:0] tx_idx = lsb_first ? bit_ff : 3'h7 - bit_ff;
	always_ff @(negedge sclk or negedge port_rst_n) begin
		if (!port_rst_n) begin
			drive_ff <= 1'b0;
			out_ff <= 1'b0;
			tx_ff <= 8'h00;
		end else begin
			drive_ff <= rd_phase;
			if (bit_ff == 3'h0) begin
				tx_ff <= rd_byte;
				out_ff <= rd_byte[tx_idx];
			end else begin
				out_ff <= tx_ff[tx_idx];
			end
		end
	end

	assign rx_byte = rx_ff;
	assign cur_addr = addr_ff;
	assign wr_addr = wr_addr_ff;
	assign wr_tgl = tgl_ff;
	assign rd_active = drive_ff;
	assign sdo_bit = out_ff;
endmodule

//--- hdl/dscp_pkg.sv
package dscp_pkg;
	typedef enum logic [1:0] {
		DSCP_INSTR,
		DSCP_DATA,
		DSCP_DONE
	} dscp_phase_t;
	typedef logic [7:0] dscp_byte_t;
	typedef logic [4:0] dscp_addr_t;
endpackage

//--- hdl/dscp_sync.sv
`timescale 1ns/1ps
module dscp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] q_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= INIT;
			q_ff <= INIT;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule

//--- hdl/dscp_top.sv
// Functional notes
// R1 - each cycle is an instruction phase then a data phase
// R2 - instruction byte captured on the first eight rising serial clock edges
// R3 - instruction gives direction, byte count and start address
// R4 - reset/mode pulse high then low restores register defaults
// R5 - reset pulse returns sequencer to instruction phase regardless of inputs
// R6 - reset mid-cycle discards partial bits, writes nothing
// R7 - data phase moves one to four bytes as coded
// R8 - write updates register right after each byte's last bit
// R9 - one shared data pin, host and device alternate driving
// R10 - single or multibyte, msb-first or lsb-first by configuration
// R11 - host pulses reset/mode high at least 50 ns after power-up
// R12 - in strap-pin mode host may leave reset/mode high
// R13 - host should prefer multibyte transfers
// R14 - bit 7 read/write, bits 6:5 count, bits 4:0 address
// R15 - sample on rising edge, drive on falling, serial clock up to 25 MHz
// R16 - chip select low for whole cycle; pin released while high
// R17 - address decrements msb-first, increments lsb-first, holds at ends
// R18 - device drives pin only during read data bytes
// R19 - chip select rising abandons cycle; restart at instruction phase
`timescale 1ns/1ps
`include "dscp_cfg.svh"
module dscp_top
	import dscp_pkg::*;
(
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic SDIO_I,
	output logic SDIO_O,
	output logic SDIO_OE,
	input wire logic RESET_MODE_PIN,
	output logic STRAP_PIN_MODE,
	output logic LOW_BIT_FIRST_SELECT,
	output logic [255:0] CFG_REGS
);
	dscp_byte_t regs_ff [`DSCP_REG_COUNT];
	logic [255:0] flat_ff;
	logic [7:0] hi_cnt_ff;
	logic pulse_seen_ff;
	logic sclr_ff;
	logic mode_ff;
	logic tgl_d_ff;

	logic rm_s;
	logic tgl_s;
	dscp_byte_t rx_byte;
	dscp_addr_t wr_addr;
	dscp_addr_t cur_addr;
	logic wr_tgl;
	logic rd_active;
	logic sdo_bit;

	dscp_sync #(.WIDTH(1), .INIT(1'b1)) u_rm (.clk(MCLK), .rst_n(NRST), .d(RESET_MODE_PIN), .q(rm_s));
	// held byte and address read only after the toggle crosses
	dscp_sync #(.WIDTH(1), .INIT(1'b0)) u_tg (.clk(MCLK), .rst_n(NRST), .d(wr_tgl), .q(tgl_s));

	// R5 R6 R16 R19 link held in reset by pin, deselect or power reset
	wire port_rst_n = NRST && !CS_N && !RESET_MODE_PIN;
	// R10 bit order from control register
	wire lsb_first = regs_ff[`DSCP_CTRL_ADDR][`DSCP_CTRL_LSB_FIRST_BIT];
	wire dscp_byte_t rd_byte = regs_ff[cur_addr];

	dscp_link u_link (
		.sclk(SCLK),
		.port_rst_n(port_rst_n),
		.hold_rst_n(NRST),
		.sdio_in(SDIO_I),
		.lsb_first(lsb_first),
		.rd_byte(rd_byte),
		.rx_byte(rx_byte),
		.cur_addr(cur_addr),
		.wr_addr(wr_addr),
		.wr_tgl(wr_tgl),
		.rd_active(rd_active),
		.sdo_bit(sdo_bit)
	);

	// R4 R11 pulse of at least the least width, then low
	wire pulse_ok = (hi_cnt_ff >= 8'(`DSCP_RESET_PULSE_CYC));
	wire pulse_end = !rm_s && pulse_seen_ff;
	wire [7:0] nxt_hi_cnt = pulse_ok ? hi_cnt_ff : hi_cnt_ff + 8'h01;
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			hi_cnt_ff <= 8'h00;
			pulse_seen_ff <= 1'b0;
			sclr_ff <= 1'b0;
		end else begin
			sclr_ff <= pulse_end;
			if (rm_s) begin
				hi_cnt_ff <= nxt_hi_cnt;
				pulse_seen_ff <= (nxt_hi_cnt >= 8'(`DSCP_RESET_PULSE_CYC));
			end else begin
				hi_cnt_ff <= 8'h00;
				pulse_seen_ff <= 1'b0;
			end
		end
	end

	// R12 strap-pin mode while pin stays high
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			mode_ff <= 1'b1;
		end else begin
			mode_ff <= rm_s;
		end
	end

	// R8 write on arrival of each completed byte
	wire wr_evt = (tgl_s != tgl_d_ff) && !rm_s;
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			tgl_d_ff <= 1'b0;
		end else begin
			tgl_d_ff <= tgl_s;
		end
	end

	// R4 R6 defaults on pulse end, writes blocked while pin high
	genvar gi;
	generate
		for (gi = 0; gi < `DSCP_REG_COUNT; gi++) begin : g_reg
			always_ff @(posedge MCLK or negedge NRST) begin
				if (!NRST) begin
					regs_ff[gi] <= (gi == 0) ? `DSCP_CTRL_RESET : `DSCP_REG_RESET;
				end else if (sclr_ff) begin
					regs_ff[gi] <= (gi == 0) ? `DSCP_CTRL_RESET : `DSCP_REG_RESET;
				end else if (wr_evt && (wr_addr == 5'(gi))) begin
					regs_ff[gi] <= rx_byte;
				end
			end
			always_ff @(posedge MCLK or negedge NRST) begin
				if (!NRST) begin
					flat_ff[gi*8 +: 8] <= 8'h00;
				end else begin
					flat_ff[gi*8 +: 8] <= regs_ff[gi];
				end
			end
		end
	endgenerate

	// R9 R16 R18 enable flop cleared while deselected
	assign SDIO_O = sdo_bit;
	assign SDIO_OE = rd_active;
	assign STRAP_PIN_MODE = mode_ff;
	assign LOW_BIT_FIRST_SELECT = lsb_first;
	assign CFG_REGS = flat_ff;
endmodule
